// ### src/basc_top.sv
`timescale 1ns/1ns
`include "basc_map.svh"
// Summary of operation
// - LCD window data passes when pass bit is 1, inverted when it is 0.
// - Inversion means two's complement, applied to reads and writes alike.
// - Window is LCD space only with high-region select 0; then pass bit counts.
// - High-region select 1 gives ISA memory, pass bit ignored, never inverted.
// - Reserved bits are written as 0 by software and read back as 0.
// - Page-ROM wait codes 10, 01, 00 give 1, 2, 3 clocks; 11 reserved.
// - Page-ROM wait applies only with page ROM enabled for that bank.
// - LCD window wait codes 011..000 give 2, 4, 6, 8 clocks; 1xx reserved.
// - ISA window wait gives 8 minus code clocks, 1 to 8.
// - System bus wait 101 gives 3 rising to 8 at 000; 11x reserved.
// - ROM wait 111 gives 2 rising to 9 clocks at code 000.
// - All-zero fields are slowest, all-one fastest except LCD window and page ROM, where it runs slowest; reset starts slowest.
// - High-region select maps the window as ISA memory at 1, LCD at 0.
module basc_top (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_ACC_START,
  input wire logic [1:0] I_ACC_TARGET,
  input wire logic I_ACC_BANK,
  input wire logic [15:0] I_ACC_WDATA,
  input wire logic [15:0] I_BUS_RDATA,
  output logic O_ACC_BUSY,
  output logic O_ACC_DONE,
  output logic [3:0] O_ACC_WAIT,
  output logic O_ACC_INVERT,
  output logic [15:0] O_BUS_WDATA,
  output logic [15:0] O_ACC_RDATA
);

  basc_pkg::basc_regs_type r;
  basc_pkg::basc_regs_type next_r;
  logic timer_last;
  logic take;
  logic [3:0] sel_wait;
  logic sel_invert;

  // Two's complement of a 16-bit data word.
  function automatic logic [15:0] twos(input logic [15:0] d);
    twos = (~d) + 16'h0001;
  endfunction

  // Address decode of one AHB transfer to a register select.
  function automatic basc_pkg::basc_sel_type decode(input logic [31:0] a);
    if (a == (`BASC_LCD_CTRL_IDX << 2)) begin
      decode = basc_pkg::BASC_SEL_LCD;
    end else if (a == (`BASC_SPEED_IDX << 2)) begin
      decode = basc_pkg::BASC_SEL_SPEED;
    end else if (a == `BASC_REGION_ADDR) begin
      decode = basc_pkg::BASC_SEL_REGION;
    end else if (a == `BASC_STATUS_ADDR) begin
      decode = basc_pkg::BASC_SEL_STATUS;
    end else begin
      decode = basc_pkg::BASC_SEL_NONE;
    end
  endfunction

  // Wait count for a target from the speed and region settings.
  function automatic logic [3:0] wait_of(input logic [1:0] tgt, input logic bank,
                                         input logic [15:0] spd, input logic [15:0] rgn);
    logic [2:0] win;
    logic [2:0] sys;
    logic [2:0] rom;
    logic [1:0] prom;
    logic page;
    win = spd[`BASC_WIN_MSB:`BASC_WIN_LSB];
    sys = spd[`BASC_SYS_MSB:`BASC_SYS_LSB];
    rom = spd[`BASC_ROM_MSB:`BASC_ROM_LSB];
    prom = spd[`BASC_PROM_MSB:`BASC_PROM_LSB];
    page = bank ? rgn[`BASC_PRE2_BIT] : rgn[`BASC_PRE0_BIT];
    wait_of = `BASC_ROM_SLOWEST;
    if (tgt == basc_pkg::BASC_TGT_WINDOW) begin
      if (rgn[`BASC_HRS_BIT]) begin
        wait_of = `BASC_ISA_SLOWEST - {1'b0, win};
      end else begin
        if (win[2]) begin
          wait_of = `BASC_LCD_SLOWEST;
        end else begin
          wait_of = `BASC_LCD_SLOWEST - {win[1:0], 1'b0};
        end
      end
    end else if (tgt == basc_pkg::BASC_TGT_SYSBUS) begin
      if (sys[2] && sys[1]) begin
        wait_of = `BASC_SYS_FASTEST;
      end else begin
        wait_of = `BASC_SYS_SLOWEST - {1'b0, sys};
      end
    end else if (page) begin
      if (prom == 2'h3) begin
        wait_of = `BASC_PROM_SLOWEST;
      end else begin
        wait_of = `BASC_PROM_SLOWEST - {2'b00, prom};
      end
    end else begin
      wait_of = `BASC_ROM_SLOWEST - {1'b0, rom};
    end
  endfunction

  // Settings seen by an access starting this cycle.
  assign take = I_ACC_START && (r.state == basc_pkg::BASC_IDLE);
  assign sel_wait = wait_of(I_ACC_TARGET, I_ACC_BANK, r.access_speed_select, r.region_control);
  assign sel_invert = (I_ACC_TARGET == basc_pkg::BASC_TGT_WINDOW) &&
                      !r.region_control[`BASC_HRS_BIT] &&
                      !r.lcd_data_control[`BASC_PASS_BIT];

  basc_wait_timer #(
    .WIDTH(4)
  ) u_timer (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_ce(I_CE),
    .i_load(take),
    .i_count(sel_wait),
    .o_last(timer_last)
  );

  // Register writes, read-back and the access sequencer in one pass.
  // Read data come from the next values so a read right after a write sees it.
  always_comb begin
    next_r = r;
    next_r.hreadyout = 1'b1;
    next_r.hresp = 1'b0;
    next_r.done = 1'b0;
    next_r.rsync1 = I_BUS_RDATA;
    next_r.rsync2 = r.rsync1;
    if (r.ap_write) begin
      unique case (r.ap_sel)
        basc_pkg::BASC_SEL_LCD: begin
          next_r.lcd_data_control = I_HWDATA[15:0] & `BASC_LCD_MASK;
        end
        basc_pkg::BASC_SEL_SPEED: begin
          next_r.access_speed_select = I_HWDATA[15:0] & `BASC_SPEED_MASK;
        end
        basc_pkg::BASC_SEL_REGION: begin
          next_r.region_control = I_HWDATA[15:0] & `BASC_REGION_MASK;
        end
        basc_pkg::BASC_SEL_NONE, basc_pkg::BASC_SEL_STATUS: begin
        end
      endcase
    end
    next_r.ap_write = 1'b0;
    next_r.ap_sel = basc_pkg::BASC_SEL_NONE;
    unique case (r.state)
      basc_pkg::BASC_IDLE: begin
        if (take) begin
          next_r.state = basc_pkg::BASC_HOLD;
          next_r.busy = 1'b1;
          next_r.target = I_ACC_TARGET;
          next_r.wait_cnt = sel_wait;
          next_r.invert = sel_invert;
          next_r.wdata_out = sel_invert ? twos(I_ACC_WDATA) : I_ACC_WDATA;
        end
      end
      basc_pkg::BASC_HOLD: begin
        if (timer_last) begin
          next_r.state = basc_pkg::BASC_IDLE;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.rdata_out = r.invert ? twos(r.rsync2) : r.rsync2;
        end
      end
    endcase
    // Address phase of a new transfer.
    if (I_HSEL && I_HREADY && I_HTRANS[1]) begin
      next_r.ap_write = I_HWRITE;
      next_r.ap_sel = decode(I_HADDR);
      next_r.hrdata = 32'h00000000;
      if (!I_HWRITE) begin
        unique case (decode(I_HADDR))
          basc_pkg::BASC_SEL_LCD: begin
            next_r.hrdata = {16'h0000, next_r.lcd_data_control};
          end
          basc_pkg::BASC_SEL_SPEED: begin
            next_r.hrdata = {16'h0000, next_r.access_speed_select};
          end
          basc_pkg::BASC_SEL_REGION: begin
            next_r.hrdata = {16'h0000, next_r.region_control};
          end
          basc_pkg::BASC_SEL_STATUS: begin
            next_r.hrdata = {23'h000000, next_r.invert, next_r.wait_cnt,
                             1'b0, next_r.target, next_r.busy};
          end
          basc_pkg::BASC_SEL_NONE: begin
          end
        endcase
      end
    end
  end

  // All state frozen while the clock enable is low.
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      r <= '0;
      r.hreadyout <= 1'b1;
      r.lcd_data_control <= `BASC_RESET_VAL;
      r.access_speed_select <= `BASC_RESET_VAL;
      r.region_control <= `BASC_RESET_VAL;
    end else if (I_CE) begin
      r <= next_r;
    end
  end

  assign O_HRDATA = r.hrdata;
  assign O_HREADYOUT = r.hreadyout;
  assign O_HRESP = r.hresp;
  assign O_ACC_BUSY = r.busy;
  assign O_ACC_DONE = r.done;
  assign O_ACC_WAIT = r.wait_cnt;
  assign O_ACC_INVERT = r.invert;
  assign O_BUS_WDATA = r.wdata_out;
  assign O_ACC_RDATA = r.rdata_out;

  // Helper: bus clocks spent busy in the current access.
  logic [3:0] ast_len;
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ast_len <= 4'h0;
    end else if (I_CE) begin
      ast_len <= r.busy ? ast_len + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_take(logic [1:0] t);
    I_CE && take && (I_ACC_TARGET == t);
  endsequence

  AST_HOLD_LENGTH: assert property (
    (I_CE && r.busy && timer_last) |-> (ast_len + 4'h1 == r.wait_cnt))
    else $error("Access hold length differs from selected wait.");

  AST_LCD_INVERT: assert property (
    (s_take(basc_pkg::BASC_TGT_WINDOW) ##0 !r.region_control[0] ##0 !r.lcd_data_control[0])
    |=> (O_BUS_WDATA == (~$past(I_ACC_WDATA)) + 16'h0001) && O_ACC_INVERT)
    else $error("LCD write data not complemented.");

  AST_LCD_PASS: assert property (
    (s_take(basc_pkg::BASC_TGT_WINDOW) ##0 r.lcd_data_control[0])
    |=> (O_BUS_WDATA == $past(I_ACC_WDATA)) && !O_ACC_INVERT)
    else $error("LCD write data changed with pass bit set.");

  AST_ISA_NO_INVERT: assert property (
    (s_take(basc_pkg::BASC_TGT_WINDOW) ##0 r.region_control[0])
    |=> !O_ACC_INVERT && (O_BUS_WDATA == $past(I_ACC_WDATA)))
    else $error("ISA window data was inverted.");

  AST_RESERVED_ZERO: assert property (
    (r.lcd_data_control[15:1] == 15'h0000) && (r.access_speed_select[15:14] == 2'b00) &&
    !r.access_speed_select[11] && !r.access_speed_select[7] && !r.access_speed_select[3])
    else $error("Reserved bit holds a one.");

  AST_PAGE_WAIT: assert property (
    (s_take(basc_pkg::BASC_TGT_ROM) ##0 !I_ACC_BANK ##0 r.region_control[1] ##0
     (r.access_speed_select[13:12] == 2'b10)) |=> (O_ACC_WAIT == 4'h1))
    else $error("Page ROM code 10 not one clock.");

  AST_LCD_WAIT: assert property (
    (s_take(basc_pkg::BASC_TGT_WINDOW) ##0 !r.region_control[0] ##0
     (r.access_speed_select[10:8] == 3'b011)) |=> (O_ACC_WAIT == 4'h2))
    else $error("LCD code 011 not two clocks.");

  AST_ISA_WAIT: assert property (
    (s_take(basc_pkg::BASC_TGT_WINDOW) ##0 r.region_control[0] ##0
     (r.access_speed_select[10:8] == 3'b111)) |=> (O_ACC_WAIT == 4'h1))
    else $error("ISA code 111 not one clock.");

  AST_SYS_WAIT: assert property (
    (s_take(basc_pkg::BASC_TGT_SYSBUS) ##0 (r.access_speed_select[6:4] == 3'b101))
    |=> (O_ACC_WAIT == 4'h3))
    else $error("System bus code 101 not three clocks.");

  AST_ROM_WAIT: assert property (
    (s_take(basc_pkg::BASC_TGT_ROM) ##0 !I_ACC_BANK ##0 !r.region_control[1] ##0
     (r.access_speed_select[2:0] == 3'b000)) |=> (O_ACC_WAIT == 4'h9))
    else $error("ROM code 000 not nine clocks.");

endmodule // basc_top

// ### src/basc_map.svh
`ifndef BASC_MAP_SVH
`define BASC_MAP_SVH

// Register indices; a byte address is four times its index.
`define BASC_LCD_CTRL_IDX 32'h0b000002
`define BASC_SPEED_IDX 32'h0b00000a
// Extra byte addresses for window and page-ROM control and for status.
`define BASC_REGION_ADDR 32'h2c000020
`define BASC_STATUS_ADDR 32'h2c000024

// Reset value and writable-bit masks; reserved bits stay zero.
`define BASC_RESET_VAL 16'h0000
`define BASC_LCD_MASK 16'h0001
`define BASC_SPEED_MASK 16'h3777
`define BASC_REGION_MASK 16'h0007

// Field positions.
`define BASC_PASS_BIT 0
`define BASC_PROM_MSB 13
`define BASC_PROM_LSB 12
`define BASC_WIN_MSB 10
`define BASC_WIN_LSB 8
`define BASC_SYS_MSB 6
`define BASC_SYS_LSB 4
`define BASC_ROM_MSB 2
`define BASC_ROM_LSB 0
`define BASC_HRS_BIT 0
`define BASC_PRE0_BIT 1
`define BASC_PRE2_BIT 2

// Wait counts in bus clocks.
`define BASC_ISA_SLOWEST 4'h8
`define BASC_SYS_SLOWEST 4'h8
`define BASC_SYS_FASTEST 4'h3
`define BASC_ROM_SLOWEST 4'h9
`define BASC_LCD_SLOWEST 4'h8
`define BASC_PROM_SLOWEST 4'h3

`endif

// ### src/basc_pkg.sv
package basc_pkg;

  // Targets of a bus access.
  typedef enum logic [1:0] {
    BASC_TGT_WINDOW,
    BASC_TGT_SYSBUS,
    BASC_TGT_ROM
  } basc_target_type;

  // Access sequencer states.
  typedef enum logic {
    BASC_IDLE,
    BASC_HOLD
  } basc_acc_state_type;

  // Register select decoded in the address phase.
  typedef enum logic [2:0] {
    BASC_SEL_NONE,
    BASC_SEL_LCD,
    BASC_SEL_SPEED,
    BASC_SEL_REGION,
    BASC_SEL_STATUS
  } basc_sel_type;

  typedef struct packed {
    logic [3:0] cnt;
  } basc_timer_type;

  typedef struct packed {
    logic [15:0] lcd_data_control;
    logic [15:0] access_speed_select;
    logic [15:0] region_control;
    logic ap_write;
    basc_sel_type ap_sel;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    basc_acc_state_type state;
    logic [1:0] target;
    logic invert;
    logic [3:0] wait_cnt;
    logic [15:0] wdata_out;
    logic [15:0] rdata_out;
    logic done;
    logic busy;
    logic [15:0] rsync1;
    logic [15:0] rsync2;
  } basc_regs_type;

endpackage

// ### src/basc_wait_timer.sv
`timescale 1ns/1ns
module basc_wait_timer #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [3:0] i_count,
  output logic o_last
);

  basc_pkg::basc_timer_type r;
  basc_pkg::basc_timer_type next_r;

  // Load wins over counting so a new access never inherits a stale count.
  always_comb begin
    next_r = r;
    if (i_load) begin
      next_r.cnt = i_count;
    end else if (r.cnt != 4'h0) begin
      next_r.cnt = r.cnt - 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  // The final bus clock of the hold is the one with one count left.
  assign o_last = (r.cnt == 4'h1);

endmodule // basc_wait_timer

// ### tb/basc_bus_model.sv
`timescale 1ns/1ns
// Device pins on the far side of the bus cycle generator.
module basc_bus_model (
  input wire logic i_clk,
  input wire logic i_drive,
  input wire logic [15:0] i_data,
  output logic [15:0] o_rdata
);
  initial o_rdata = 16'h0000;
  // A released data bus has no pull, so it shows the inverse of the last driven word.
  // A design that sampled after release would then see a wrong value.
  always @(posedge i_clk) begin
    o_rdata <= i_drive ? i_data : ~i_data;
  end
endmodule // basc_bus_model

// ### tb/tb_top.sv
`timescale 1ns/1ns
`include "basc_map.svh"
module tb_top;
  localparam logic [31:0] a_lcd = 32'(`BASC_LCD_CTRL_IDX * 4);
  localparam logic [31:0] a_spd = 32'(`BASC_SPEED_IDX * 4);
  localparam logic [31:0] a_rgn = `BASC_REGION_ADDR;
  localparam logic [31:0] a_sts = `BASC_STATUS_ADDR;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic acc_start = 1'b0;
  logic [1:0] acc_target = 2'h0;
  logic acc_bank = 1'b0;
  logic [15:0] acc_wdata = 16'h0;
  logic [15:0] bus_rdata;
  logic acc_busy, acc_done, acc_invert;
  logic [3:0] acc_wait;
  logic [15:0] bus_wdata, acc_rdata;
  logic drv = 1'b0;
  logic [15:0] drv_data = 16'h0;
  logic [31:0] rd;
  int err_count = 0;
  int check_count = 0;

  basc_top i_basc_top (.I_CLK_SYS(clk_sys), .I_RST_N(rst_n), .I_CE(1'b1), .I_HSEL(1'b1),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout),
    .O_HRESP(hresp), .I_ACC_START(acc_start), .I_ACC_TARGET(acc_target),
    .I_ACC_BANK(acc_bank), .I_ACC_WDATA(acc_wdata), .I_BUS_RDATA(bus_rdata),
    .O_ACC_BUSY(acc_busy), .O_ACC_DONE(acc_done), .O_ACC_WAIT(acc_wait),
    .O_ACC_INVERT(acc_invert), .O_BUS_WDATA(bus_wdata), .O_ACC_RDATA(acc_rdata));
  basc_bus_model i_basc_bus_model (.i_clk(clk_sys), .i_drive(drv), .i_data(drv_data),
    .o_rdata(bus_rdata));

  // Free-running system clock, 20 ns period.
  always #10 clk_sys = ~clk_sys;

  // Compare, count and report at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  // One single AHB-Lite transfer; waits on hready in both phases.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (hreadyout !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk_sys); k++; end while (hreadyout !== 1'b1 && k < 100);
    rd = hrdata;
    // A wait that ran out of its limit is a mismatch, not a silent pass.
    chk(32'(hreadyout), 32'h1, "bus ready timeout");
    chk(32'(hresp), 32'h0, "bus response");
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    ahb(1'b1, a, {16'h0000, d});
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input string m);
    ahb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask

  // One access; start is held one edge into busy so that the repeat must be ignored.
  task automatic run_acc(input logic [1:0] tgt, input logic bank, input logic [15:0] wd,
      input logic [3:0] n, input logic inv, input logic [15:0] bwd, input logic [15:0] rdv,
      input logic [15:0] erd);
    int k;
    acc_target <= tgt;
    acc_bank <= bank;
    acc_wdata <= wd;
    drv <= 1'b1;
    drv_data <= rdv;
    repeat (4) @(posedge clk_sys);
    acc_start <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(32'(acc_wait), 32'(n), "wait count");
    chk(32'(acc_invert), 32'(inv), "invert flag");
    chk(32'(bus_wdata), 32'(bwd), "bus write data");
    k = 0;
    while (acc_busy === 1'b1 && k < 20) begin
      k++;
      @(posedge clk_sys);
      acc_start <= 1'b0;
      #1;
    end
    chk(32'(k), 32'(n), "busy length");
    chk(32'(acc_done), 32'h1, "done pulse");
    chk(32'(acc_rdata), 32'(erd), "read result");
    @(posedge clk_sys);
    drv <= 1'b0;
  endtask

  task automatic t_reset;
    rchk(a_lcd, 32'h0, "lcd reset");
    rchk(a_spd, 32'h0, "speed reset");
    rchk(a_rgn, 32'h0, "region reset");
    rchk(a_sts, 32'h0, "status reset");
    run_acc(2'h2, 1'b0, 16'h00a5, 4'h9, 1'b0, 16'h00a5, 16'h0033, 16'h0033);
    $display("test reset done");
  endtask

  task automatic t_reserved;
    // Only writable bits are set in the LCD and speed writes; region and unmapped writes set all bits.
    wr(a_lcd, 16'h0001);
    rchk(a_lcd, 32'h0001, "lcd reserved bits");
    wr(a_spd, 16'h3777);
    rchk(a_spd, 32'h3777, "speed reserved bits");
    wr(a_rgn, 16'hffff);
    rchk(a_rgn, 32'h0007, "region reserved bits");
    wr(32'h2c000030, 16'hffff);
    rchk(32'h2c000030, 32'h0, "unmapped read");
    wr(a_rgn, 16'h0000);
    $display("test reserved done");
  endtask

  // Sweeps one wait field; expected clocks are base minus step per code.
  task automatic t_wait(input logic [1:0] tgt, input logic bank, input logic [15:0] rgn,
      input logic [15:0] ext, input int shift, input int cnt, input int base, input int step);
    wr(a_rgn, rgn);
    for (int c = 0; c < cnt; c++) begin
      wr(a_spd, ext | 16'(c << shift));
      run_acc(tgt, bank, 16'h00a5, 4'(base - step * c), 1'b0, 16'h00a5, 16'h005a, 16'h005a);
    end
    $display("test wait sweep done");
  endtask

  task automatic t_data;
    wr(a_spd, 16'h0333);
    wr(a_lcd, 16'h0000);
    wr(a_rgn, 16'h0000);
    run_acc(2'h0, 1'b0, 16'h1234, 4'h2, 1'b1, 16'hedcc, 16'h0005, 16'hfffb);
    // Status shows invert at bit 8, wait 2 in bits 7:4, window target, idle.
    rchk(a_sts, 32'h0120, "status after access");
    run_acc(2'h2, 1'b0, 16'h1234, 4'h6, 1'b0, 16'h1234, 16'h0005, 16'h0005);
    wr(a_rgn, 16'h0001);
    run_acc(2'h0, 1'b0, 16'h1234, 4'h5, 1'b0, 16'h1234, 16'h0005, 16'h0005);
    wr(a_lcd, 16'h0001);
    wr(a_rgn, 16'h0000);
    run_acc(2'h0, 1'b0, 16'h1234, 4'h2, 1'b0, 16'h1234, 16'h0005, 16'h0005);
    // Reserved window code falls back to the slowest LCD timing; target code 3 runs as ROM.
    wr(a_spd, 16'h3777);
    run_acc(2'h0, 1'b0, 16'h1234, 4'h8, 1'b0, 16'h1234, 16'h0005, 16'h0005);
    run_acc(2'h3, 1'b0, 16'h1234, 4'h2, 1'b0, 16'h1234, 16'h0005, 16'h0005);
    $display("test data path done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence: reset for ten cycles, then the scenarios in turn.
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_reserved();
    t_wait(2'h2, 1'b0, 16'h0, 16'h0, 0, 8, 9, 1);
    t_wait(2'h1, 1'b0, 16'h0, 16'h0, 4, 6, 8, 1);
    wr(a_lcd, 16'h0001);
    t_wait(2'h0, 1'b0, 16'h0, 16'h0, 8, 4, 8, 2);
    t_wait(2'h0, 1'b0, 16'h1, 16'h0, 8, 8, 8, 1);
    t_wait(2'h2, 1'b0, 16'h2, 16'h0007, 12, 3, 3, 1);
    t_wait(2'h2, 1'b1, 16'h4, 16'h0007, 12, 3, 3, 1);
    t_wait(2'h2, 1'b1, 16'h2, 16'h2007, 0, 1, 2, 0);
    t_data();
    final_report();
  end

  // Watchdog sized well beyond the few hundred cycles the scenarios need.
  initial begin
    #400000;
    err_count++;
    $display("unexpected %0t watchdog expired", $time);
    final_report();
  end
endmodule // tb_top
